// ### sim/hpc_host_model.sv
module hpc_host_model (
    input  wire logic          i_clk_sys,
    output logic               o_cfg_wr_en,
    output hpc_pkg::hpc_src_t  o_cfg_wr_src,
    output logic [7:0]         o_cfg_wr_addr,
    output logic [7:0]         o_cfg_wr_data
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_cfg_wr_en   = 1'b0;
        o_cfg_wr_src  = hpc_pkg::HPC_SRC_SMBUS;
        o_cfg_wr_addr = 8'hFF;
        o_cfg_wr_data = 8'hFF;
    end

    // one byte per strobe; idle cycles model a slow loader
    task automatic wr(input hpc_pkg::hpc_src_t src, input logic [7:0] a, input logic [7:0] d,
                      input int unsigned idle);
        logic [7:0] dd;
        dd = d;
        if (a == hpc_pkg::PORT_USED_CONFIG_OFFSET && dd[0] == 1'b0 && dd[2] == 1'b0) begin
            dd[0] = 1'b1;
        end
        repeat (idle) @(negedge i_clk_sys);
        @(negedge i_clk_sys);
        o_cfg_wr_en   = 1'b1;
        o_cfg_wr_src  = src;
        o_cfg_wr_addr = a;
        o_cfg_wr_data = dd;
        @(negedge i_clk_sys);
        // released lines must not keep the last value
        o_cfg_wr_en   = 1'b0;
        o_cfg_wr_addr = ~a;
        o_cfg_wr_data = ~dd;
    endtask : wr
endmodule : hpc_host_model

// ### sim/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic               i_clk_sys;
    logic               i_reset_n;
    hpc_pkg::hpc_mode_t i_cfg_mode;
    logic               i_cfg_rd_en;
    logic [7:0]         i_cfg_rd_addr;
    logic [3:0]         i_power_charge_pins;
    logic               i_power_polarity_pin;
    logic [3:0]         i_otp_non_removable;
    logic [3:0]         i_otp_port_used;
    logic [3:0]         i_otp_high_speed_only;
    logic               i_otp_hi_current;
    logic               wr_en;
    hpc_pkg::hpc_src_t  wr_src;
    logic [7:0]         wr_addr;
    logic [7:0]         wr_data;
    logic [7:0]         o_cfg_rd_data;
    logic               o_cfg_rd_valid;
    logic               o_cfg_ready;
    logic [3:0]         o_charge_port_enable;
    logic [3:0]         o_port_removable;
    logic [3:0]         o_port_used;
    logic [3:0]         o_high_speed_only_port;
    logic [7:0]         o_device_config_second;
    int                 n_fail;
    int                 checks_done;

    hpc_host_model host (
        .i_clk_sys     (i_clk_sys),
        .o_cfg_wr_en   (wr_en),
        .o_cfg_wr_src  (wr_src),
        .o_cfg_wr_addr (wr_addr),
        .o_cfg_wr_data (wr_data)
    );

    hpc_port_config dut (
        .i_clk_sys              (i_clk_sys),
        .i_reset_n              (i_reset_n),
        .i_cfg_mode             (i_cfg_mode),
        .i_cfg_wr_en            (wr_en),
        .i_cfg_wr_src           (wr_src),
        .i_cfg_wr_addr          (wr_addr),
        .i_cfg_wr_data          (wr_data),
        .i_cfg_rd_en            (i_cfg_rd_en),
        .i_cfg_rd_addr          (i_cfg_rd_addr),
        .i_power_charge_pins    (i_power_charge_pins),
        .i_power_polarity_pin   (i_power_polarity_pin),
        .i_otp_non_removable    (i_otp_non_removable),
        .i_otp_port_used        (i_otp_port_used),
        .i_otp_high_speed_only  (i_otp_high_speed_only),
        .i_otp_hi_current       (i_otp_hi_current),
        .o_cfg_rd_data          (o_cfg_rd_data),
        .o_cfg_rd_valid         (o_cfg_rd_valid),
        .o_cfg_ready            (o_cfg_ready),
        .o_charge_port_enable   (o_charge_port_enable),
        .o_port_removable       (o_port_removable),
        .o_port_used            (o_port_used),
        .o_high_speed_only_port (o_high_speed_only_port),
        .o_device_config_second (o_device_config_second)
    );

    always #5 i_clk_sys = ~i_clk_sys;

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // read latency is one cycle; the bound only guards against a hang
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        int i;
        @(negedge i_clk_sys);
        i_cfg_rd_en   = 1'b1;
        i_cfg_rd_addr = a;
        @(negedge i_clk_sys);
        i_cfg_rd_en   = 1'b0;
        i_cfg_rd_addr = ~a;
        for (i = 0; i < 4; i++) begin
            if (o_cfg_rd_valid === 1'b1) break;
            @(posedge i_clk_sys);
            #1;
        end
        if (i == 4) begin
            n_fail++;
            $display("ERROR %s expected valid seen none", nm);
            conclude();
        end else begin
            chk(nm, o_cfg_rd_data, exp);
        end
    endtask : rd

    task automatic do_reset(input logic [3:0] pins);
        int i;
        i_reset_n           = 1'b0;
        i_power_charge_pins = pins;
        repeat (3) @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        for (i = 0; i < 10 && o_cfg_ready !== 1'b1; i++) @(negedge i_clk_sys);
        if (i == 10) begin
            n_fail++;
            $display("ERROR ready expected 1 seen %b", o_cfg_ready);
            conclude();
        end
    endtask : do_reset

    initial begin
        i_clk_sys             = 1'b0;
        n_fail                = 0;
        checks_done           = 0;
        i_cfg_mode            = hpc_pkg::HPC_MODE_PINS;
        i_cfg_rd_en           = 1'b0;
        i_cfg_rd_addr         = 8'h00;
        i_power_polarity_pin  = 1'b1;
        i_otp_non_removable   = 4'h3;
        i_otp_port_used       = 4'hF;
        i_otp_high_speed_only = 4'h0;
        i_otp_hi_current      = 1'b1;
        do_reset(4'hA);
        chk("charge_out", {4'h0, o_charge_port_enable}, 8'h0A);
        rd(8'h06, 8'h0A, "charge_reg");
        rd(8'h07, 8'h0C, "removable_reg");
        rd(8'h08, 8'h0F, "used_reg");
        rd(8'h0A, 8'h30, "dev_cfg2");
        rd(8'h20, 8'h00, "unmapped");
        host.wr(hpc_pkg::HPC_SRC_SMBUS, 8'h06, 8'h00, 0);
        rd(8'h06, 8'h0A, "pin_mode_write");
        $display("test reset_capture done");

        i_cfg_mode = hpc_pkg::HPC_MODE_SMBUS;
        host.wr(hpc_pkg::HPC_SRC_SMBUS, 8'h08, 8'h05, 0);
        rd(8'h08, 8'h0F, "used_locked");
        host.wr(hpc_pkg::HPC_SRC_SMBUS, 8'h07, 8'h03, 2);
        rd(8'h07, 8'h0C, "removable_locked");
        host.wr(hpc_pkg::HPC_SRC_SMBUS, 8'h06, 8'hFF, 0);
        rd(8'h06, 8'h0F, "charge_smbus");
        chk("charge_bits", {4'h0, o_charge_port_enable}, 8'h0F);
        host.wr(hpc_pkg::HPC_SRC_EEPROM, 8'h06, 8'h00, 0);
        rd(8'h06, 8'h0F, "wrong_source");
        i_cfg_mode = hpc_pkg::HPC_MODE_I2C;
        host.wr(hpc_pkg::HPC_SRC_EEPROM, 8'h06, 8'h05, 3);
        rd(8'h06, 8'h05, "charge_eeprom");
        chk("charge_port1_3", {4'h0, o_charge_port_enable}, 8'h05);
        $display("test locked_and_charge done");

        i_cfg_mode = hpc_pkg::HPC_MODE_SMBUS;
        host.wr(hpc_pkg::HPC_SRC_SMBUS, 8'h07, 8'h85, 0);
        chk("removable_out", {4'h0, o_port_removable}, 8'h05);
        rd(8'h07, 8'h85, "unlock_and_removable");
        host.wr(hpc_pkg::HPC_SRC_SMBUS, 8'h08, 8'h0E, 0);
        rd(8'h08, 8'h0E, "used_unlocked");
        chk("used_out", {4'h0, o_port_used}, 8'h0E);
        host.wr(hpc_pkg::HPC_SRC_SMBUS, 8'h09, 8'h01, 0);
        chk("hso_out", {4'h0, o_high_speed_only_port}, 8'h01);
        chk("used_forced", {4'h0, o_port_used}, 8'h0F);
        rd(8'h08, 8'h0E, "used_field_kept");
        host.wr(hpc_pkg::HPC_SRC_SMBUS, 8'h07, 8'h00, 0);
        rd(8'h07, 8'h0C, "relock");
        chk("used_relock", {4'h0, o_port_used}, 8'h0F);
        host.wr(hpc_pkg::HPC_SRC_SMBUS, 8'h0A, 8'hC6, 0);
        rd(8'h0A, 8'h46, "dev_cfg2_custom");
        host.wr(hpc_pkg::HPC_SRC_SMBUS, 8'h0A, 8'h00, 0);
        rd(8'h0A, 8'h10, "dev_cfg2_locked");
        $display("test unlock done");

        do_reset(4'h5);
        rd(8'h06, 8'h05, "charge_second_reset");
        rd(8'h07, 8'h0C, "unlock_cleared");
        rd(8'h0A, 8'h30, "dev_cfg2_second_reset");
        $display("test second_reset done");
        conclude();
    end
endmodule : tb

// ### verilog/hpc_locked_field.sv
module hpc_locked_field #(
    parameter int unsigned       WIDTH = 4,
    parameter logic [WIDTH-1:0]  RESET = '0
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_reset_n,
    input  wire logic             i_unlock,
    input  wire logic             i_unlock_rise,
    input  wire logic             i_wr,
    input  wire logic [WIDTH-1:0] i_wdata,
    input  wire logic [WIDTH-1:0] i_otp_value,
    output logic      [WIDTH-1:0] o_value
);
    logic [WIDTH-1:0] custom_q;
    logic [WIDTH-1:0] custom_d;

    // on unlock without data the field starts from the otp view, so it does not jump
    always_comb begin
        custom_d = custom_q;
        if (i_wr) begin
            custom_d = i_wdata;
        end else if (i_unlock_rise) begin
            custom_d = i_otp_value;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            custom_q <= RESET;
        end else begin
            custom_q <= custom_d;
        end
    end

    assign o_value = i_unlock ? custom_q : i_otp_value;

endmodule : hpc_locked_field

// ### verilog/hpc_pkg.sv
package hpc_pkg;

    localparam int unsigned PORT_COUNT = 4;

    // register offsets
    localparam logic [7:0] CHARGE_SUPPORT_ENABLES_OFFSET = 8'h06;
    localparam logic [7:0] REMOVABLE_CONFIG_OFFSET       = 8'h07;
    localparam logic [7:0] PORT_USED_CONFIG_OFFSET       = 8'h08;
    localparam logic [7:0] HIGH_SPEED_ONLY_OFFSET        = 8'h09;
    localparam logic [7:0] DEVICE_CONFIG_SECOND_OFFSET   = 8'h0A;

    // field positions
    localparam int unsigned UNLOCK_BIT         = 7;
    localparam int unsigned BC_CUSTOM_BIT      = 6;
    localparam int unsigned PWR_POLARITY_BIT   = 5;
    localparam int unsigned HI_CURRENT_BIT     = 4;
    localparam int unsigned RSVD_RW_LSB        = 2;
    localparam int unsigned AUTO_MODE_OFF_BIT  = 1;

    // values after reset
    localparam logic [3:0] PORT_USED_RESET       = 4'hF;
    localparam logic [3:0] HIGH_SPEED_ONLY_RESET = 4'h0;
    localparam logic [0:0] HI_CURRENT_RESET      = 1'h1;
    localparam logic [1:0] RSVD_RW_RESET         = 2'h0;
    localparam logic [0:0] AUTO_MODE_OFF_RESET   = 1'h0;
    localparam logic [0:0] UNLOCK_RESET          = 1'h0;

    // configuration mode as seen by the block
    typedef enum logic [1:0] {
        HPC_MODE_PINS  = 2'b00,
        HPC_MODE_I2C   = 2'b01,
        HPC_MODE_SMBUS = 2'b10
    } hpc_mode_t;

    // originator of a configuration write
    typedef enum logic [0:0] {
        HPC_SRC_EEPROM = 1'b0,
        HPC_SRC_SMBUS  = 1'b1
    } hpc_src_t;

endpackage : hpc_pkg

// ### verilog/hpc_port_config.sv
// Operation
// - charge enable bit n drives downstream port n+1
// - charge enable 1 turns charging features on, 0 leaves them off
// - charge enable field captured from power/charge pins at reset release
// - in i2c or smbus mode eeprom or smbus host may overwrite charge enables
// - reserved upper bits of charge and removable registers read zero
// - unlock 0 makes removable, used, high-speed-only follow otp; 1 makes them writable
// - one write may set unlock and new removable value together
// - while locked removable reads as inverse of otp non-removable bits
// - removable bit n describes port n+1, 1 removable, 0 fixed
// - high-speed-only port stays used regardless of used bit
// - i2c mode loads from eeprom; smbus mode lets host overwrite
module hpc_port_config (
    input  wire logic                                 i_clk_sys,
    input  wire logic                                 i_reset_n,
    input  wire hpc_pkg::hpc_mode_t                   i_cfg_mode,
    input  wire logic                                 i_cfg_wr_en,
    input  wire hpc_pkg::hpc_src_t                    i_cfg_wr_src,
    input  wire logic [7:0]                           i_cfg_wr_addr,
    input  wire logic [7:0]                           i_cfg_wr_data,
    input  wire logic                                 i_cfg_rd_en,
    input  wire logic [7:0]                           i_cfg_rd_addr,
    input  wire logic [hpc_pkg::PORT_COUNT-1:0]       i_power_charge_pins,
    input  wire logic                                 i_power_polarity_pin,
    input  wire logic [hpc_pkg::PORT_COUNT-1:0]       i_otp_non_removable,
    input  wire logic [hpc_pkg::PORT_COUNT-1:0]       i_otp_port_used,
    input  wire logic [hpc_pkg::PORT_COUNT-1:0]       i_otp_high_speed_only,
    input  wire logic                                 i_otp_hi_current,
    output logic      [7:0]                           o_cfg_rd_data,
    output logic                                      o_cfg_rd_valid,
    output logic                                      o_cfg_ready,
    output logic      [hpc_pkg::PORT_COUNT-1:0]       o_charge_port_enable,
    output logic      [hpc_pkg::PORT_COUNT-1:0]       o_port_removable,
    output logic      [hpc_pkg::PORT_COUNT-1:0]       o_port_used,
    output logic      [hpc_pkg::PORT_COUNT-1:0]       o_high_speed_only_port,
    output logic      [7:0]                           o_device_config_second
);
    localparam int unsigned N = hpc_pkg::PORT_COUNT;

    logic [N-1:0] strap_charge;
    logic         strap_done;
    logic [0:0]   strap_pol;
    logic         strap_pol_done;
    logic         wr_ok;
    logic         wr_charge;
    logic         wr_remov;
    logic         wr_used;
    logic         wr_hso;
    logic         wr_dc2;

    logic [N-1:0] charge_q;
    logic [N-1:0] charge_d;
    logic         unlock_q;
    logic         unlock_d;
    logic         bc_custom_q;
    logic         bc_custom_d;
    logic         pol_q;
    logic         pol_d;
    logic [1:0]   rsvd_rw_q;
    logic [1:0]   rsvd_rw_d;
    logic         auto_off_q;
    logic         auto_off_d;
    logic         loaded_q;
    logic         loaded_d;
    logic [7:0]   rd_data_q;
    logic [7:0]   rd_data_d;
    logic         rd_valid_q;
    logic         rd_valid_d;

    logic [N-1:0] remov_val;
    logic [N-1:0] used_val;
    logic [N-1:0] hso_val;
    logic [0:0]   hicur_val;
    logic         unlock_rise;
    logic         bc_rise;

    hpc_strap_capture #(.WIDTH(N)) u_charge_strap (
        .i_clk_sys  (i_clk_sys),
        .i_reset_n  (i_reset_n),
        .i_pins     (i_power_charge_pins),
        .o_value    (strap_charge),
        .o_captured (strap_done)
    );

    hpc_strap_capture #(.WIDTH(1)) u_pol_strap (
        .i_clk_sys  (i_clk_sys),
        .i_reset_n  (i_reset_n),
        .i_pins     (i_power_polarity_pin),
        .o_value    (strap_pol),
        .o_captured (strap_pol_done)
    );

    // eeprom loads only count in i2c mode, host writes only in smbus mode
    always_comb begin
        wr_ok = 1'b0;
        if (i_cfg_wr_en && loaded_q) begin
            unique case (i_cfg_mode)
                hpc_pkg::HPC_MODE_I2C:   wr_ok = (i_cfg_wr_src == hpc_pkg::HPC_SRC_EEPROM);
                hpc_pkg::HPC_MODE_SMBUS: wr_ok = (i_cfg_wr_src == hpc_pkg::HPC_SRC_SMBUS);
                hpc_pkg::HPC_MODE_PINS:  wr_ok = 1'b0;
                default:                 wr_ok = 1'b0;
            endcase
        end
    end

    assign wr_charge = wr_ok && (i_cfg_wr_addr == hpc_pkg::CHARGE_SUPPORT_ENABLES_OFFSET);
    assign wr_remov  = wr_ok && (i_cfg_wr_addr == hpc_pkg::REMOVABLE_CONFIG_OFFSET);
    assign wr_used   = wr_ok && (i_cfg_wr_addr == hpc_pkg::PORT_USED_CONFIG_OFFSET);
    assign wr_hso    = wr_ok && (i_cfg_wr_addr == hpc_pkg::HIGH_SPEED_ONLY_OFFSET);
    assign wr_dc2    = wr_ok && (i_cfg_wr_addr == hpc_pkg::DEVICE_CONFIG_SECOND_OFFSET);

    // configuration state
    always_comb begin
        charge_d    = charge_q;
        unlock_d    = unlock_q;
        bc_custom_d = bc_custom_q;
        pol_d       = pol_q;
        rsvd_rw_d   = rsvd_rw_q;
        auto_off_d  = auto_off_q;
        loaded_d    = loaded_q | (strap_done & strap_pol_done);
        if (strap_done && !loaded_q) begin
            charge_d = strap_charge;
            pol_d    = strap_pol[0];
        end
        if (wr_charge) begin
            charge_d = i_cfg_wr_data[N-1:0];
        end
        if (wr_remov) begin
            unlock_d = i_cfg_wr_data[hpc_pkg::UNLOCK_BIT];
        end
        if (wr_dc2) begin
            bc_custom_d = i_cfg_wr_data[hpc_pkg::BC_CUSTOM_BIT];
            pol_d       = i_cfg_wr_data[hpc_pkg::PWR_POLARITY_BIT];
            rsvd_rw_d   = i_cfg_wr_data[hpc_pkg::RSVD_RW_LSB +: 2];
            auto_off_d  = i_cfg_wr_data[hpc_pkg::AUTO_MODE_OFF_BIT];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            charge_q    <= '0;
            unlock_q    <= hpc_pkg::UNLOCK_RESET;
            bc_custom_q <= 1'b0;
            pol_q       <= 1'b0;
            rsvd_rw_q   <= hpc_pkg::RSVD_RW_RESET;
            auto_off_q  <= hpc_pkg::AUTO_MODE_OFF_RESET;
            loaded_q    <= 1'b0;
        end else begin
            charge_q    <= charge_d;
            unlock_q    <= unlock_d;
            bc_custom_q <= bc_custom_d;
            pol_q       <= pol_d;
            rsvd_rw_q   <= rsvd_rw_d;
            auto_off_q  <= auto_off_d;
            loaded_q    <= loaded_d;
        end
    end

    assign unlock_rise = unlock_d & ~unlock_q;
    assign bc_rise     = bc_custom_d & ~bc_custom_q;

    // the new unlock value gates the same write, so unlock and data land together
    hpc_locked_field #(.WIDTH(N), .RESET('0)) u_removable (
        .i_clk_sys     (i_clk_sys),
        .i_reset_n     (i_reset_n),
        .i_unlock      (unlock_q),
        .i_unlock_rise (unlock_rise),
        .i_wr          (wr_remov & unlock_d),
        .i_wdata       (i_cfg_wr_data[N-1:0]),
        .i_otp_value   (~i_otp_non_removable),
        .o_value       (remov_val)
    );

    hpc_locked_field #(.WIDTH(N), .RESET(hpc_pkg::PORT_USED_RESET)) u_used (
        .i_clk_sys     (i_clk_sys),
        .i_reset_n     (i_reset_n),
        .i_unlock      (unlock_q),
        .i_unlock_rise (unlock_rise),
        .i_wr          (wr_used & unlock_q),
        .i_wdata       (i_cfg_wr_data[N-1:0]),
        .i_otp_value   (i_otp_port_used),
        .o_value       (used_val)
    );

    hpc_locked_field #(.WIDTH(N), .RESET(hpc_pkg::HIGH_SPEED_ONLY_RESET)) u_hso (
        .i_clk_sys     (i_clk_sys),
        .i_reset_n     (i_reset_n),
        .i_unlock      (unlock_q),
        .i_unlock_rise (unlock_rise),
        .i_wr          (wr_hso & unlock_q),
        .i_wdata       (i_cfg_wr_data[N-1:0]),
        .i_otp_value   (i_otp_high_speed_only),
        .o_value       (hso_val)
    );

    hpc_locked_field #(.WIDTH(1), .RESET(hpc_pkg::HI_CURRENT_RESET)) u_hicur (
        .i_clk_sys     (i_clk_sys),
        .i_reset_n     (i_reset_n),
        .i_unlock      (bc_custom_q),
        .i_unlock_rise (bc_rise),
        .i_wr          (wr_dc2 & bc_custom_d),
        .i_wdata       (i_cfg_wr_data[hpc_pkg::HI_CURRENT_BIT]),
        .i_otp_value   (i_otp_hi_current),
        .o_value       (hicur_val)
    );

    // register read port, one cycle latency; unmapped offsets read zero
    always_comb begin
        rd_data_d  = rd_data_q;
        rd_valid_d = i_cfg_rd_en;
        if (i_cfg_rd_en) begin
            unique case (i_cfg_rd_addr)
                hpc_pkg::CHARGE_SUPPORT_ENABLES_OFFSET: rd_data_d = {4'h0, charge_q};
                hpc_pkg::REMOVABLE_CONFIG_OFFSET:       rd_data_d = {unlock_q, 3'h0, remov_val};
                hpc_pkg::PORT_USED_CONFIG_OFFSET:       rd_data_d = {4'h0, used_val};
                hpc_pkg::HIGH_SPEED_ONLY_OFFSET:        rd_data_d = {4'h0, hso_val};
                hpc_pkg::DEVICE_CONFIG_SECOND_OFFSET:   rd_data_d = o_device_config_second;
                default:                                rd_data_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    assign o_cfg_rd_data  = rd_data_q;
    assign o_cfg_rd_valid = rd_valid_q;
    assign o_cfg_ready    = loaded_q;

    assign o_charge_port_enable   = charge_q;
    assign o_port_removable       = remov_val;
    assign o_port_used            = used_val | hso_val;
    assign o_high_speed_only_port = hso_val;
    assign o_device_config_second = {1'b0, bc_custom_q, pol_q, hicur_val, rsvd_rw_q, auto_off_q, 1'b0};

    property p_strap_capture;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (strap_done && !loaded_q) |=> (o_charge_port_enable == $past(strap_charge));
    endproperty
    a_strap_capture: assert property (p_strap_capture) else $error("charge enables not taken from pins");

    property p_charge_write;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        wr_charge |=> (o_charge_port_enable == $past(i_cfg_wr_data[3:0]));
    endproperty
    a_charge_write: assert property (p_charge_write) else $error("charge enable write not applied");

    property p_no_write_in_pin_mode;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_cfg_mode == hpc_pkg::HPC_MODE_PINS && loaded_q) |=> $stable(charge_q) && $stable(unlock_q);
    endproperty
    a_no_write_in_pin_mode: assert property (p_no_write_in_pin_mode) else $error("write taken in pin mode");

    property p_reserved_zero;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_cfg_rd_en && (i_cfg_rd_addr == hpc_pkg::CHARGE_SUPPORT_ENABLES_OFFSET
                      || i_cfg_rd_addr == hpc_pkg::REMOVABLE_CONFIG_OFFSET))
        |=> (o_cfg_rd_data[6:4] == 3'h0) && o_cfg_rd_valid;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read non-zero");

    property p_locked_follows_otp;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        !unlock_q |-> (o_port_removable == ~i_otp_non_removable) && (used_val == i_otp_port_used);
    endproperty
    a_locked_follows_otp: assert property (p_locked_follows_otp) else $error("locked field not from otp");

    property p_unlock_with_data;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (wr_remov && i_cfg_wr_data[7]) |=> unlock_q && (o_port_removable == $past(i_cfg_wr_data[3:0]));
    endproperty
    a_unlock_with_data: assert property (p_unlock_with_data) else $error("combined unlock write lost data");

    property p_locked_write_ignored;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (wr_used && !unlock_q && !unlock_d) |=> ##1 (used_val == i_otp_port_used);
    endproperty
    a_locked_write_ignored: assert property (p_locked_write_ignored) else $error("locked used write applied");

    property p_hs_only_used;
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (o_high_speed_only_port != 4'h0) |-> ((o_port_used & o_high_speed_only_port) == o_high_speed_only_port);
    endproperty
    a_hs_only_used: assert property (p_hs_only_used) else $error("high-speed-only port not used");

    property p_used_reset;
        @(posedge i_clk_sys) $rose(i_reset_n) |-> (u_used.custom_q == hpc_pkg::PORT_USED_RESET);
    endproperty
    a_used_reset: assert property (p_used_reset) else $error("used field reset not all ones");

endmodule : hpc_port_config

// ### verilog/hpc_strap_capture.sv
module hpc_strap_capture #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_reset_n,
    input  wire logic [WIDTH-1:0] i_pins,
    output logic      [WIDTH-1:0] o_value,
    output logic                  o_captured
);
    logic [WIDTH-1:0] value_q;
    logic [WIDTH-1:0] value_d;
    logic             captured_q;
    logic             captured_d;

    // pins sampled once, on the first edge after release
    always_comb begin
        value_d    = value_q;
        captured_d = 1'b1;
        if (!captured_q) begin
            value_d = i_pins;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            value_q    <= '0;
            captured_q <= 1'b0;
        end else begin
            value_q    <= value_d;
            captured_q <= captured_d;
        end
    end

    assign o_value    = value_q;
    assign o_captured = captured_q;

endmodule : hpc_strap_capture
